// ==== pkg/epsc_consts.vh ====
// Constants for the external pin state control block
`ifndef EPSC_CONSTS_VH
`define EPSC_CONSTS_VH
`define EPSC_PERIPH_INTERNAL 8'hf0
`define EPSC_REG_PAR_DEBUG 4'h8
`define EPSC_REG_SER_CTRL 4'hb
`define EPSC_REG_SER_DATA 4'hf
`define EPSC_SER_CTRL_RESET 8'h03
`define EPSC_SER_CE_BIT 0
`define EPSC_SER_WP_BIT 1
`define EPSC_SER_CLOCKED_BIT 2
`define EPSC_CLK_PERIOD_NS 10
`define EPSC_PHASE_DIV 50
`define EPSC_PHASE_A_END 6'd12
`define EPSC_PHASE_B_START 6'd25
`define EPSC_PHASE_B_END 6'd37
`define EPSC_BITS_PER_CYCLE 6'd55
`define EPSC_SUPPLY_SETTLE 16384
`define EPSC_BOOT_CYCLES 32
`define EPSC_SHIFT_BITS 4'd8
`define EPSC_SCK_HALF 4'd8
`endif

// ==== rtl/epsc_sync3.v ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module epsc_sync3 #(
	parameter RST_VAL = 1'b0
) (
	input wire clk,
	input wire reset_n,
	input wire din,
	output reg dout
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	always @(posedge clk) begin
		if (!reset_n) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// Change accepted only once the last two stages agree
			if (s2_q == s3_q)
				dout <= s3_q;
		end
	end
endmodule // epsc_sync3
`default_nettype wire

// ==== rtl/epsc_top.v ====
// External pin state control: sleep states, debug port, serial, supply
`timescale 1ns/1ps
`default_nettype none
`include "epsc_consts.vh"
// Operation
// - Upper chip select low only for upper-half accesses, high otherwise.
// - Idle memory data bus carries low 16 bits of C register while running, zero otherwise.
// - Read strobe low only in access; undriven in power-down.
// - Write strobe low only in access; undriven in power-down.
// - Debug bits 7:5 show turbo state; bit 4 clocked serial mode.
// - Debug bit 3 internal peripheral selected; bit 2 external bus owner.
// - Debug bit 1 address time; bit 0 last instruction cycle.
// - Debug pulse toggles on each parallel control register write.
// - Register and instruction buses precharged low while phase A high.
// - Phase B rising edges mark bit times; instruction marker and power-off instruction act there.
// - Run indicator shows running; instruction clears it at fixed point.
// - External drive of run indicator stops running: light sleep if display held, else deep sleep.
// - Battery-connect input keeps memory management disabled at start.
// - Serial chip enable and write protect pins are active-low, driven low while running when their control bits are set.
// - Each clocked serial transfer gives exactly eight clock pulses.
// - Serial data passes through shared serial data register.
// - Instruction marker high at instruction time; copies display power off.
// - Supply request asserted when any power-up condition appears.
// - Supply acknowledge after settling; low level resets processor.
// - Light sleep drives defined idle levels; deep sleep mostly undriven.
// - Light sleep: powered, oscillator running, core held in reset.
// - Outside accesses memory controls inactive and address zero.
module epsc_top #(
	parameter SETTLE_CYCLES = `EPSC_SUPPLY_SETTLE
) (
	input wire clk,
	input wire reset_n,
	input wire battery_connect_n,
	input wire on_key_n,
	input wire isa_wake_in,
	input wire display_power_in,
	input wire run_force_in,
	input wire legacy_map_enable,
	input wire mem_access,
	input wire mem_write,
	input wire [22:0] mem_addr_in,
	input wire [15:0] mem_wdata,
	input wire [15:0] c_reg_low,
	input wire [2:0] turbo_state,
	input wire [7:0] periph_addr,
	input wire ext_bus_owner,
	input wire address_time,
	input wire instr_time,
	input wire last_instr_cycle,
	input wire power_off_cmd,
	input wire reg_wr,
	input wire reg_rd,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire serial_shift_in,
	output reg [7:0] reg_rdata,
	output reg [7:0] serial_data,
	output wire legacy_map_active,
	output wire mmu_enable_allow,
	output reg [22:0] mem_address_bus,
	output wire mem_address_oe,
	output reg [15:0] mem_data_bus,
	output wire mem_data_oe,
	output reg upper_mem_select_n,
	output reg lower_mem_select_n,
	output wire lower_mem_select_oe,
	output reg mem_read_strobe_n,
	output wire mem_read_strobe_oe,
	output reg mem_write_strobe_n,
	output wire mem_write_strobe_oe,
	output reg [7:0] debug_status_port,
	output reg debug_write_pulse,
	output wire debug_oe,
	output reg clock_phase_a,
	output reg clock_phase_b,
	output wire phase_oe,
	output wire bus_precharge_low,
	output reg run_indicator,
	output reg instr_marker,
	output reg serial_chip_enable_n,
	output reg serial_write_protect_n,
	output reg serial_clock,
	output reg serial_shift_out,
	output wire serial_oe,
	output reg supply_request,
	output reg supply_ack,
	output wire core_reset_n
);
	localparam ST_DEEP = 4'b0001;
	localparam ST_SETTLE = 4'b0010;
	localparam ST_LIGHT = 4'b0100;
	localparam ST_RUN = 4'b1000;
	localparam [15:0] SETTLE_LAST = SETTLE_CYCLES - 1;
	localparam [5:0] BOOT_LAST = `EPSC_BOOT_CYCLES - 1;
	localparam [5:0] DIV_LAST = `EPSC_PHASE_DIV - 1;

	wire batt_s;
	wire on_s;
	wire wake_s;
	wire disp_s;
	wire force_s;
	wire legacy_s;
	wire sdi_s;
	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [15:0] settle_q;
	reg [5:0] boot_q;
	reg [5:0] div_q;
	reg [5:0] bit_q;
	reg mmu_allow_q;
	reg [7:0] ser_ctrl_q;
	reg [7:0] shift_q;
	reg [3:0] shift_cnt_q;
	reg [3:0] sck_div_q;
	reg shifting_q;
	reg powered;
	reg running;
	reg light;
	wire phase_b_rise;
	wire internal_sel;
	wire pwr_cond;

	epsc_sync3 #(.RST_VAL(1'b1)) u_batt (.clk(clk), .reset_n(reset_n),
		.din(battery_connect_n), .dout(batt_s));
	epsc_sync3 #(.RST_VAL(1'b1)) u_on (.clk(clk), .reset_n(reset_n),
		.din(on_key_n), .dout(on_s));
	epsc_sync3 #(.RST_VAL(1'b0)) u_wake (.clk(clk), .reset_n(reset_n),
		.din(isa_wake_in), .dout(wake_s));
	epsc_sync3 #(.RST_VAL(1'b0)) u_disp (.clk(clk), .reset_n(reset_n),
		.din(display_power_in), .dout(disp_s));
	epsc_sync3 #(.RST_VAL(1'b0)) u_force (.clk(clk), .reset_n(reset_n),
		.din(run_force_in), .dout(force_s));
	epsc_sync3 #(.RST_VAL(1'b0)) u_legacy (.clk(clk), .reset_n(reset_n),
		.din(legacy_map_enable), .dout(legacy_s));
	epsc_sync3 #(.RST_VAL(1'b0)) u_sdi (.clk(clk), .reset_n(reset_n),
		.din(serial_shift_in), .dout(sdi_s));

	assign legacy_map_active = legacy_s;
	assign internal_sel = (periph_addr == `EPSC_PERIPH_INTERNAL);
	// Key pressed, display power held or a wake source in deep sleep
	assign pwr_cond = !on_s || wake_s || disp_s;

	always @* begin
		powered = (state_q == ST_LIGHT) || (state_q == ST_RUN);
		running = (state_q == ST_RUN);
		light = (state_q == ST_LIGHT);
	end

	// Power state sequencing
	always @* begin
		state_d = state_q;
		case (state_q)
		ST_DEEP: begin
			if (pwr_cond)
				state_d = ST_SETTLE;
		end
		ST_SETTLE: begin
			if (settle_q == SETTLE_LAST)
				state_d = ST_LIGHT;
		end
		ST_LIGHT: begin
			// A held display alone keeps standby; only key or wake runs
			if (!disp_s && !wake_s && on_s)
				state_d = ST_DEEP;
			else if (boot_q == BOOT_LAST && (wake_s || !on_s))
				state_d = ST_RUN;
		end
		ST_RUN: begin
			// Run indicator dropped by instruction or outside force
			if (force_s)
				state_d = disp_s ? ST_LIGHT : ST_DEEP;
			else if (power_off_cmd && phase_b_rise && bit_q == 6'd0)
				state_d = disp_s ? ST_LIGHT : ST_DEEP;
		end
		default: state_d = ST_DEEP;
		endcase
	end

	always @(posedge clk) begin
		if (!reset_n) begin
			state_q <= ST_DEEP;
			settle_q <= 16'h0000;
			boot_q <= 6'h00;
			supply_request <= 1'b0;
			supply_ack <= 1'b0;
			run_indicator <= 1'b0;
			mmu_allow_q <= 1'b0;
		end else begin
			state_q <= state_d;
			settle_q <= (state_q == ST_SETTLE) ? settle_q + 16'h0001 :
				16'h0000;
			boot_q <= (light && boot_q != BOOT_LAST) ? boot_q + 6'h01 :
				(powered ? boot_q : 6'h00);
			supply_request <= (state_d != ST_DEEP);
			supply_ack <= (state_d == ST_LIGHT) || (state_d == ST_RUN);
			run_indicator <= (state_d == ST_RUN);
			// Fresh battery holds memory management off until first run
			if (!batt_s)
				mmu_allow_q <= 1'b0;
			else if (running)
				mmu_allow_q <= 1'b1;
		end
	end
	assign core_reset_n = supply_ack && running;
	assign mmu_enable_allow = mmu_allow_q;

	// Phase generator from the 100 MHz clock
	always @(posedge clk) begin
		// Cleared on the leaving edge so no phase survives into standby
		if (!reset_n || state_d != ST_RUN) begin
			div_q <= 6'h00;
			bit_q <= 6'h00;
			clock_phase_a <= 1'b0;
			clock_phase_b <= 1'b0;
		end else begin
			div_q <= (div_q == DIV_LAST) ? 6'h00 : div_q + 6'h01;
			if (div_q == DIV_LAST)
				bit_q <= (bit_q == `EPSC_BITS_PER_CYCLE) ? 6'h00 :
					bit_q + 6'h01;
			clock_phase_a <= (div_q < `EPSC_PHASE_A_END);
			clock_phase_b <= (div_q >= `EPSC_PHASE_B_START) &&
				(div_q < `EPSC_PHASE_B_END);
		end
	end
	assign phase_b_rise = running && (div_q == `EPSC_PHASE_B_START);
	assign phase_oe = powered;
	assign bus_precharge_low = clock_phase_a;

	// Legacy-compatible marker moves on phase B rise, copies display power off
	always @(posedge clk) begin
		if (!reset_n)
			instr_marker <= 1'b0;
		else if (!running)
			instr_marker <= disp_s;
		else if (phase_b_rise)
			instr_marker <= instr_time;
	end

	// Memory pins: idle levels between accesses
	always @(posedge clk) begin
		if (!reset_n) begin
			mem_address_bus <= 23'h000000;
			mem_data_bus <= 16'h0000;
			upper_mem_select_n <= 1'b1;
			lower_mem_select_n <= 1'b1;
			mem_read_strobe_n <= 1'b1;
			mem_write_strobe_n <= 1'b1;
		end else if (running && mem_access) begin
			mem_address_bus <= mem_addr_in;
			mem_data_bus <= mem_write ? mem_wdata : c_reg_low;
			upper_mem_select_n <= !mem_addr_in[22];
			lower_mem_select_n <= mem_addr_in[22];
			mem_read_strobe_n <= mem_write;
			mem_write_strobe_n <= !mem_write;
		end else begin
			mem_address_bus <= 23'h000000;
			// Idle data is zero while core is in reset, C low otherwise
			mem_data_bus <= running ? c_reg_low : 16'h0000;
			upper_mem_select_n <= 1'b1;
			lower_mem_select_n <= 1'b1;
			mem_read_strobe_n <= 1'b1;
			mem_write_strobe_n <= 1'b1;
		end
	end
	assign mem_address_oe = powered;
	assign mem_data_oe = powered && !(running && mem_access && !mem_write);
	assign lower_mem_select_oe = powered;
	assign mem_read_strobe_oe = powered;
	assign mem_write_strobe_oe = powered;

	// Debug port and write pulse
	always @(posedge clk) begin
		if (!reset_n) begin
			debug_status_port <= 8'h00;
			debug_write_pulse <= 1'b0;
		end else if (!running) begin
			debug_status_port <= 8'h00;
			debug_write_pulse <= 1'b0;
		end else begin
			debug_status_port <= {turbo_state,
				ser_ctrl_q[`EPSC_SER_CLOCKED_BIT],
				internal_sel, ext_bus_owner,
				address_time, last_instr_cycle};
			if (reg_wr && internal_sel && reg_addr == `EPSC_REG_PAR_DEBUG)
				debug_write_pulse <= !debug_write_pulse;
		end
	end
	assign debug_oe = powered;

	// Serial control and clocked byte shifter
	always @(posedge clk) begin
		if (!reset_n || !powered) begin
			ser_ctrl_q <= `EPSC_SER_CTRL_RESET;
			shift_q <= 8'h00;
			shift_cnt_q <= 4'h0;
			sck_div_q <= 4'h0;
			shifting_q <= 1'b0;
			serial_clock <= 1'b1;
			serial_data <= 8'h00;
		end else begin
			if (reg_wr && internal_sel && reg_addr == `EPSC_REG_SER_CTRL) begin
				ser_ctrl_q <= reg_wdata;
				// Write with clocked mode set while no byte is shifting loads and starts a byte
				if (reg_wdata[`EPSC_SER_CLOCKED_BIT] && !shifting_q) begin
					shift_q <= serial_data;
					shift_cnt_q <= 4'h0;
					sck_div_q <= 4'h0;
					shifting_q <= 1'b1;
				end
			end
			if (shifting_q) begin
				sck_div_q <= (sck_div_q == `EPSC_SCK_HALF - 4'h1) ? 4'h0 :
					sck_div_q + 4'h1;
				if (sck_div_q == `EPSC_SCK_HALF - 4'h1) begin
					serial_clock <= !serial_clock;
					if (!serial_clock) begin
						shift_q <= {shift_q[6:0], sdi_s};
						shift_cnt_q <= shift_cnt_q + 4'h1;
						if (shift_cnt_q == `EPSC_SHIFT_BITS - 4'h1) begin
							shifting_q <= 1'b0;
							serial_data <= {shift_q[6:0], sdi_s};
						end
					end
				end
			end else if (!(reg_wr && internal_sel &&
				reg_addr == `EPSC_REG_SER_CTRL)) begin
				if (reg_wr && internal_sel && reg_addr == `EPSC_REG_SER_DATA)
					serial_data <= reg_wdata;
			end
		end
	end

	// Serial pins; idle high in light sleep
	always @(posedge clk) begin
		if (!reset_n) begin
			serial_chip_enable_n <= 1'b1;
			serial_write_protect_n <= 1'b1;
			serial_shift_out <= 1'b1;
		end else begin
			serial_chip_enable_n <= !(running &&
				ser_ctrl_q[`EPSC_SER_CE_BIT]);
			serial_write_protect_n <= !(running &&
				ser_ctrl_q[`EPSC_SER_WP_BIT]);
			serial_shift_out <= shifting_q ? shift_q[7] : 1'b1;
		end
	end
	assign serial_oe = powered;

	// Register reads
	always @(posedge clk) begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else if (reg_rd && internal_sel) begin
			case (reg_addr)
			`EPSC_REG_SER_CTRL: reg_rdata <= {ser_ctrl_q[7:4], shifting_q,
				ser_ctrl_q[2:0]};
			`EPSC_REG_SER_DATA: reg_rdata <= serial_data;
			default: reg_rdata <= 8'h00;
			endcase
		end
	end
endmodule // epsc_top
`default_nettype wire

// ==== verif/epsc_top_asserts.sv ====
// Port assertions for the external pin state control block
`timescale 1ns/1ps
`default_nettype none
`include "epsc_consts.vh"
module epsc_top_asserts #(
	parameter SETTLE_CYCLES = `EPSC_SUPPLY_SETTLE
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic core_reset_n,
	input wire logic reg_wr,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] periph_addr,
	input wire logic upper_mem_select_n,
	input wire logic mem_read_strobe_oe,
	input wire logic mem_write_strobe_oe,
	input wire logic clock_phase_a,
	input wire logic clock_phase_b,
	input wire logic bus_precharge_low,
	input wire logic run_indicator,
	input wire logic debug_write_pulse,
	input wire logic serial_chip_enable_n,
	input wire logic serial_write_protect_n,
	input wire logic supply_request,
	input wire logic supply_ack
);
	int wait_q;
	wire sel = periph_addr == `EPSC_PERIPH_INTERNAL && core_reset_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Counts settling so an early acknowledge cannot slip through
	always @(posedge clk) begin
		if (!reset_n || !supply_request)
			wait_q <= 0;
		else if (!supply_ack)
			wait_q <= wait_q + 1;
	end
	upper_idle_a: assert property (!supply_ack |-> upper_mem_select_n)
		else $error("upper select active while unpowered");
	strobe_float_a: assert property (!supply_request |->
		!mem_read_strobe_oe && !mem_write_strobe_oe)
		else $error("strobe driven in power-down");
	bus_precharge_a: assert property (bus_precharge_low == clock_phase_a &&
		!(clock_phase_a && clock_phase_b))
		else $error("precharge does not follow phase a");
	phase_width_a: assert property ($rose(clock_phase_a) |=>
		clock_phase_a [*8] ##1 !clock_phase_b)
		else $error("phase a too short");
	light_idle_a: assert property (supply_ack && !core_reset_n |->
		!clock_phase_a && !clock_phase_b && !run_indicator)
		else $error("clock or run active in light sleep");
	supply_settle_a: assert property ($rose(supply_ack) |->
		wait_q >= SETTLE_CYCLES)
		else $error("acknowledge before settling");
	request_first_a: assert property (supply_ack |-> supply_request)
		else $error("acknowledge without request");
	pulse_toggle_a: assert property (reg_wr && sel && run_indicator &&
		reg_addr == `EPSC_REG_PAR_DEBUG |=>
		debug_write_pulse != $past(debug_write_pulse))
		else $error("debug pulse did not toggle");
	ctrl_pins_a: assert property (reg_wr && sel &&
		reg_addr == `EPSC_REG_SER_CTRL |-> ##2
		serial_chip_enable_n == !$past(reg_wdata[0], 2) &&
		serial_write_protect_n == !$past(reg_wdata[1], 2))
		else $error("serial control pins wrong");
endmodule // epsc_top_asserts
`default_nettype wire

// ==== verif/epsc_sd_model.sv ====
// Serial card model on the clocked serial lines
`timescale 1ns/1ps
`default_nettype none
module epsc_sd_model (
	input wire logic serial_clock,
	input wire logic serial_chip_enable_n,
	input wire logic serial_shift_out,
	output logic serial_shift_in,
	output logic [7:0] card_rx,
	output int pulses
);
	logic [7:0] tx_q = 8'h3c;
	initial pulses = 0;
	initial card_rx = 8'h00;
	initial serial_shift_in = 1'b0;
	always @(negedge serial_clock) begin
		if (!serial_chip_enable_n) begin
			serial_shift_in <= tx_q[7];
			tx_q <= {tx_q[6:0], tx_q[7]};
		end
	end
	// Released line: invert so a stale bit never looks valid
	always @(posedge serial_chip_enable_n) serial_shift_in <= !serial_shift_in;
	always @(posedge serial_clock) begin
		pulses <= pulses + 1;
		if (!serial_chip_enable_n)
			card_rx <= {card_rx[6:0], serial_shift_out};
	end
endmodule // epsc_sd_model
`default_nettype wire

// ==== verif/epsc_top_test.sv ====
// Self-checking bench for the external pin state control block
`timescale 1ns/1ps
`default_nettype none
`include "epsc_consts.vh"
module epsc_top_test;
	logic clk = 0, reset_n = 0, battery_connect_n, on_key_n, isa_wake_in;
	logic display_power_in, run_force_in, legacy_map_enable, mem_access;
	logic mem_write, ext_bus_owner, address_time, instr_time, reg_wr, reg_rd;
	logic last_instr_cycle, power_off_cmd, exp_pls;
	logic [22:0] mem_addr_in;
	logic [15:0] mem_wdata, c_reg_low;
	logic [2:0] turbo_state, seen;
	logic [7:0] periph_addr, reg_wdata, d;
	logic [3:0] reg_addr;
	wire logic [7:0] reg_rdata, serial_data, debug_status_port;
	wire logic [22:0] mem_address_bus;
	wire logic [15:0] mem_data_bus;
	wire logic serial_shift_in, legacy_map_active, mmu_enable_allow;
	wire logic mem_address_oe, mem_data_oe, upper_mem_select_n;
	wire logic lower_mem_select_n, lower_mem_select_oe, mem_read_strobe_n;
	wire logic mem_read_strobe_oe, mem_write_strobe_n, mem_write_strobe_oe;
	wire logic debug_write_pulse, debug_oe, clock_phase_a, clock_phase_b;
	wire logic phase_oe, bus_precharge_low, run_indicator, instr_marker;
	wire logic serial_chip_enable_n, serial_write_protect_n, serial_clock;
	wire logic serial_shift_out, serial_oe, supply_request, supply_ack;
	wire logic core_reset_n;
	wire logic [7:0] card_rx;
	int err_total = 0, checks = 0, seed = 1, pulses, i, k, p0;
	int q[$];
	epsc_top #(.SETTLE_CYCLES(16)) dut (.*);
	epsc_sd_model sd (.*);
	always #5 clk = ~clk;
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(negedge clk);
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, v};
		@(negedge clk);
		reg_wr = 0;
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		{battery_connect_n, on_key_n, isa_wake_in, display_power_in} = 4'b1100;
		{run_force_in, mem_access, mem_write, power_off_cmd} = 0;
		legacy_map_enable = 1;
		{reg_wr, reg_rd, reg_addr, reg_wdata, instr_time} = 0;
		{ext_bus_owner, address_time, last_instr_cycle, turbo_state} = 0;
		{mem_addr_in, mem_wdata} = 0;
		c_reg_low = 16'($random(seed));
		periph_addr = `EPSC_PERIPH_INTERNAL;
		cyc(16);
		reset_n = 1;
		cyc(6);
		chk("upper_sel", 1, upper_mem_select_n);
		chk("rd_oe", 0, mem_read_strobe_oe);
		chk("wr_oe", 0, mem_write_strobe_oe);
		chk("vci", 0, supply_request);
		chk("legacy", 1, legacy_map_active);
		chk("oe_deep", 6'h00, {mem_address_oe, mem_data_oe,
			lower_mem_select_oe, debug_oe, phase_oe, serial_oe});
		$display("deep sleep test done");
		on_key_n = 0;
		for (i = 0; i < 300 && supply_ack !== 1; i++) cyc(1);
		chk("vci", 1, supply_request);
		chk("vco", 1, supply_ack);
		display_power_in = 1;
		chk("addr", 0, mem_address_bus);
		chk("data", 0, mem_data_bus);
		chk("pwo", 0, run_indicator);
		for (i = 0; i < 6000 && run_indicator !== 1; i++) cyc(1);
		chk("pwo", 1, run_indicator);
		on_key_n = 1;
		chk("pls", 0, debug_write_pulse);
		$display("power up test done");
		for (k = 0; k < 4; k++) begin
			{turbo_state, ext_bus_owner, address_time, last_instr_cycle,
				instr_time} = 7'($random(seed));
			cyc(60);
			d = {turbo_state, 2'b01, ext_bus_owner, address_time, last_instr_cycle};
			chk("debug_status_port", d, debug_status_port);
			chk("sync", instr_time, instr_marker);
		end
		chk("idle_data", c_reg_low, mem_data_bus);
		chk("oe_run", 6'h3f, {mem_address_oe, mem_data_oe,
			lower_mem_select_oe, debug_oe, phase_oe, serial_oe});
		chk("mmu", 1, mmu_enable_allow);
		battery_connect_n = 0;
		cyc(6);
		chk("mmu", 0, mmu_enable_allow);
		battery_connect_n = 1;
		cyc(6);
		chk("mmu", 1, mmu_enable_allow);
		for (k = 0; k < 4; k++) begin
			seen = 0;
			mem_addr_in = {k[0], 22'($random(seed))};
			{mem_write, mem_access} = {k[1], 1'b1};
			mem_wdata = 16'($random(seed));
			for (i = 0; i < 8; i++) begin
				@(negedge clk);
				if (i == 3) mem_access = 0;
				seen |= {!upper_mem_select_n, !mem_read_strobe_n, !mem_write_strobe_n};
			end
			chk("mem_ctl", {k[0], !k[1], k[1]}, seen);
			chk("mem_addr", 0, mem_address_bus);
		end
		exp_pls = 0;
		for (k = 0; k < 4; k++) begin
			periph_addr = k[1] ? 8'h20 : `EPSC_PERIPH_INTERNAL;
			wr(`EPSC_REG_PAR_DEBUG, 8'($random(seed)));
			exp_pls ^= !k[1];
			@(negedge clk);
			chk("pls", exp_pls, debug_write_pulse);
		end
		periph_addr = `EPSC_PERIPH_INTERNAL;
		$display("debug and memory test done");
		for (k = 0; k < 4; k++) begin
			wr(`EPSC_REG_SER_CTRL, 8'(k));
			q.push_back(k);
			@(negedge clk);
			chk("ce_n", !k[0], serial_chip_enable_n);
			chk("wp_n", !k[1], serial_write_protect_n);
			{reg_rd, reg_addr} = {1'b1, `EPSC_REG_SER_CTRL};
			@(negedge clk);
			reg_rd = 0;
			@(negedge clk);
			chk("ctrl", q.pop_front(), reg_rdata[2:0]);
		end
		d = 8'($random(seed));
		wr(`EPSC_REG_SER_DATA, d);
		@(negedge clk);
		chk("sdata", d, serial_data);
		p0 = pulses;
		wr(`EPSC_REG_SER_CTRL, 8'h05);
		cyc(60);
		chk("pdata4", 1, debug_status_port[4]);
		cyc(200);
		chk("sck", 8, pulses - p0);
		chk("sd_rx", d, card_rx);
		chk("sd_tx", 8'h3c, serial_data);
		chk("sck_idle", 1, serial_clock);
		$display("serial test done");
		run_force_in = 1;
		cyc(6);
		chk("pwo_force", 0, run_indicator);
		chk("core_rst", 0, core_reset_n);
		{run_force_in, on_key_n} = 2'b00;
		for (i = 0; i < 300 && run_indicator !== 1; i++) cyc(1);
		on_key_n = 1;
		chk("pwo", 1, run_indicator);
		$display("force test done");
		power_off_cmd = 1;
		for (i = 0; i < 6000 && run_indicator !== 0; i++) cyc(1);
		power_off_cmd = 0;
		chk("pwo", 0, run_indicator);
		cyc(4);
		chk("core_rst", 0, core_reset_n);
		chk("light_data", 0, mem_data_bus);
		display_power_in = 0;
		for (i = 0; i < 300 && supply_ack !== 0; i++) cyc(1);
		cyc(8);
		chk("upper_sel", 1, upper_mem_select_n);
		chk("data_oe", 0, mem_data_oe);
		chk("sync", 0, instr_marker);
		$display("power down test done");
		results;
	end
	initial begin
		#400000;
		err_total++;
		results;
	end
endmodule // epsc_top_test
bind epsc_top epsc_top_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (.*);
`default_nettype wire
